// ### pkg/slfs_pkg.sv
// Shared constants and types for the safety logic function set
package slfs_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int PULSE_TIME_NS = 100000;
    localparam int PULSE_CYCLES  = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Widths and sizes
    localparam int OR_INPUTS     = 4;
    localparam int DATA_W        = 8;
    localparam int TABLE_ENTRIES = 8;
    localparam logic [TABLE_ENTRIES*DATA_W-1:0] TABLE_INIT = 64'h0706050403020100;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] WORD_RESET  = 8'h00;
    localparam logic              FLAG_RESET  = 1'h0;

    // ==========================================================
    // Arming edge selection and start latch states
    typedef enum logic {
        RISING_ARM_SETTING,
        FALLING_ARM_SETTING
    } slfs_arm_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ON
    } slfs_start_t;
endpackage : slfs_pkg

// ### hw/slfs_table_converter.sv
// Lookup table converter with registered output word
`timescale 1ns/10ps
module slfs_table_converter #(
    parameter int                   W       = slfs_pkg::DATA_W,
    parameter int                   ENTRIES = slfs_pkg::TABLE_ENTRIES,
    parameter logic [ENTRIES*W-1:0] TABLE   = slfs_pkg::TABLE_INIT
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         conv_go,
    input  wire logic [W-1:0] conv_index,
    output logic      [W-1:0] converted_word
);
    logic [W-1:0] next_word;
    logic         in_range;

    // ==========================================================
    // Conversion
    // Entry count bounds
    assign in_range = (int'(conv_index) < ENTRIES);

    always_comb begin
        next_word = converted_word;
        if (conv_go && in_range) begin
            next_word = TABLE[int'(conv_index)*W +: W];
        end
    end

    // Output word register, zero after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            converted_word <= slfs_pkg::WORD_RESET;
        end else begin
            converted_word <= next_word;
        end
    end

    // ==========================================================
    // Checks
    logic seen;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen <= slfs_pkg::FLAG_RESET;
        end else if (conv_go) begin
            seen <= 1'h1;
        end
    end

    a_word_initial_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !seen |-> converted_word == '0) else $error("word not zero before conversion");

    a_word_converts: assert property (@(posedge clk) disable iff (!rst_n)
        conv_go && in_range |=> converted_word == TABLE[int'($past(conv_index))*W +: W])
        else $error("converted word wrong");

    // An index beyond the table leaves the word untouched
    a_word_holds: assert property (@(posedge clk) disable iff (!rst_n)
        conv_go && !in_range |=> $stable(converted_word))
        else $error("word changed on out of range index");
endmodule : slfs_table_converter

// ### hw/slfs_top.sv
// OR gate, pulse generator, start latch and table converter primitives
`timescale 1ns/10ps

// Behaviour
// - OR output high when any input high, low only when all low.
// - Falling input edge starts pulse lasting exactly the configured pulse length.
// - Start output sets on selected control edge only while permissive input is high.
// - Start output clears when permissive drops, then waits for a new arming edge.
// - Rising arm setting arms on rising edge, falling setting on falling edge.
// - Converter outputs the table entry for its input; zero after reset.
// - Table entry count is a parameter; input and output share one data type.
module slfs_top #(
    parameter int                   N_OR      = slfs_pkg::OR_INPUTS,
    parameter int                   W         = slfs_pkg::DATA_W,
    parameter int                   ENTRIES   = slfs_pkg::TABLE_ENTRIES,
    parameter logic [ENTRIES*W-1:0] TABLE     = slfs_pkg::TABLE_INIT,
    parameter int                   PULSE_LEN = slfs_pkg::PULSE_CYCLES
) (
    input  wire logic            clk,
    input  wire logic            nrst,
    input  wire logic [N_OR-1:0] or_in,
    output logic                 or_out,
    input  wire logic            pulse_in,
    output logic                 pulse_out,
    input  wire logic            start_control,
    input  wire logic            start_permit,
    input  wire logic            arm_select,
    output logic                 start_out,
    input  wire logic            conv_req,
    input  wire logic [W-1:0]    conv_index,
    output logic      [W-1:0]    converted_word
);
    localparam int CW = $clog2(PULSE_LEN + 1);
    localparam int SW = N_OR + 5 + W;

    logic            rst_meta;
    logic            rst_n;
    logic [SW-1:0]   sync1;
    logic [SW-1:0]   sync2;
    logic [N_OR-1:0] or_s;
    logic            pulse_s;
    logic            ctl_s;
    logic            permit_s;
    logic            sel_s;
    logic            req_s;
    logic [W-1:0]    index_s;

    // ==========================================================
    // Reset release and input synchronisers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'h0;
            rst_n    <= 1'h0;
        end else begin
            rst_meta <= 1'h1;
            rst_n    <= rst_meta;
        end
    end

    // Two-stage capture of every pin input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {or_in, pulse_in, start_control, start_permit, arm_select, conv_req,
                      conv_index};
            sync2 <= sync1;
        end
    end

    assign {or_s, pulse_s, ctl_s, permit_s, sel_s, req_s, index_s} = sync2;

    // ==========================================================
    // Previous samples for edge detection
    logic pulse_prev;
    logic ctl_prev;
    logic req_prev;
    logic pulse_fall;
    logic ctl_rise;
    logic ctl_fall;
    logic conv_go;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_prev <= slfs_pkg::FLAG_RESET;
            ctl_prev   <= slfs_pkg::FLAG_RESET;
            req_prev   <= slfs_pkg::FLAG_RESET;
        end else begin
            pulse_prev <= pulse_s;
            ctl_prev   <= ctl_s;
            req_prev   <= req_s;
        end
    end

    assign pulse_fall = pulse_prev & ~pulse_s;
    assign ctl_rise   = ~ctl_prev & ctl_s;
    assign ctl_fall   = ctl_prev & ~ctl_s;
    assign conv_go    = ~req_prev & req_s;

    // ==========================================================
    // OR primitive
    logic next_or;

    always_comb begin
        next_or = |or_s;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            or_out <= slfs_pkg::FLAG_RESET;
        end else begin
            or_out <= next_or;
        end
    end

    // ==========================================================
    // Pulse primitive; a new falling edge restarts the pulse
    logic [CW-1:0] pulse_cnt;
    logic [CW-1:0] next_cnt;
    logic          next_pulse;

    always_comb begin
        next_cnt   = pulse_cnt;
        next_pulse = pulse_out;
        if (pulse_fall) begin
            next_pulse = 1'h1;
            next_cnt   = CW'(PULSE_LEN - 1);
        end else if (pulse_cnt != '0) begin
            next_cnt = pulse_cnt - 1'h1;
        end else begin
            next_pulse = 1'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt <= '0;
            pulse_out <= slfs_pkg::FLAG_RESET;
        end else begin
            pulse_cnt <= next_cnt;
            pulse_out <= next_pulse;
        end
    end

    // ==========================================================
    // Start primitive
    slfs_pkg::slfs_start_t state;
    slfs_pkg::slfs_start_t next_state;
    logic                  arm_edge;
    logic                  next_start;

    assign arm_edge = (sel_s == slfs_pkg::FALLING_ARM_SETTING) ? ctl_fall : ctl_rise;

    always_comb begin
        next_state = state;
        case (state)
            slfs_pkg::ST_IDLE: begin
                if (permit_s && arm_edge) begin
                    next_state = slfs_pkg::ST_ON;
                end
            end
            slfs_pkg::ST_ON: begin
                if (!permit_s) begin
                    next_state = slfs_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = slfs_pkg::ST_IDLE;
            end
        endcase
        next_start = (next_state == slfs_pkg::ST_ON);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= slfs_pkg::ST_IDLE;
            start_out <= slfs_pkg::FLAG_RESET;
        end else begin
            state     <= next_state;
            start_out <= next_start;
        end
    end

    // ==========================================================
    // Table converter
    slfs_table_converter #(
        .W       (W),
        .ENTRIES (ENTRIES),
        .TABLE   (TABLE)
    ) u_conv (
        .clk            (clk),
        .rst_n          (rst_n),
        .conv_go        (conv_go),
        .conv_index     (index_s),
        .converted_word (converted_word)
    );

    // ==========================================================
    // Checks
    logic [CW:0] since_fall;
    logic        fall_seen;

    // Cycles since the latest falling edge, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_fall <= '0;
            fall_seen  <= slfs_pkg::FLAG_RESET;
        end else if (pulse_fall) begin
            since_fall <= (CW+1)'(1);
            fall_seen  <= 1'h1;
        end else if (int'(since_fall) <= PULSE_LEN) begin
            since_fall <= since_fall + 1'h1;
        end
    end

    a_or_asserts: assert property (@(posedge clk) disable iff (!rst_n)
        (|or_s) |=> or_out) else $error("or output missed an input");

    a_or_releases: assert property (@(posedge clk) disable iff (!rst_n)
        (or_s == '0) |=> !or_out) else $error("or output high with no input");

    a_pulse_length: assert property (@(posedge clk) disable iff (!rst_n)
        fall_seen |-> pulse_out == (int'(since_fall) <= PULSE_LEN))
        else $error("pulse length wrong");

    a_pulse_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !fall_seen |-> !pulse_out) else $error("pulse without falling edge");

    a_start_sets: assert property (@(posedge clk) disable iff (!rst_n)
        permit_s && arm_edge |=> start_out) else $error("start did not set");

    a_start_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        !permit_s && !start_out |=> !start_out) else $error("start set without permit");

    a_start_drops: assert property (@(posedge clk) disable iff (!rst_n)
        start_out && !permit_s |=> !start_out ##1 (!start_out || $past(arm_edge)))
        else $error("start held without permit");

    // Wrong polarity edge never sets the latch, in either arming setting
    a_start_polarity: assert property (@(posedge clk) disable iff (!rst_n)
        !start_out && (sel_s == slfs_pkg::FALLING_ARM_SETTING ? ctl_rise : ctl_fall)
        |=> !start_out)
        else $error("start armed on wrong edge");
endmodule : slfs_top

// ### tb/slfs_channel_model.sv
// Sensor channel model driving the primitive input pins after clock edges
`timescale 1ns/10ps
module slfs_channel_model (
    input  wire logic       clk,
    output logic      [3:0] or_in,
    output logic            pulse_in,
    output logic            start_control,
    output logic            start_permit,
    output logic            arm_select,
    output logic            conv_req,
    output logic      [7:0] conv_index
);
    // ====================
    // Idle levels at time zero
    initial begin
        {or_in, pulse_in, start_control, start_permit} = 7'h00;
        {arm_select, conv_req, conv_index} = 10'h000;
    end

    // Change one channel just after a rising edge; the level then holds
    task automatic put(input int sel, input logic [7:0] v);
        @(posedge clk);
        case (sel)
            0: or_in <= v[3:0];
            1: pulse_in <= v[0];
            2: start_control <= v[0];
            3: start_permit <= v[0];
            4: arm_select <= v[0];
            5: conv_req <= v[0];
            default: conv_index <= v;
        endcase
    endtask : put
endmodule : slfs_channel_model

// ### tb/safety_logic_function_set_tb_top.sv
// Self-checking bench for the safety logic primitives
`timescale 1ns/10ps
module safety_logic_function_set_tb_top;
    localparam int PL  = 5;
    localparam int ENT = slfs_pkg::TABLE_ENTRIES;
    typedef struct {int at; int sel; logic [7:0] val;} slfs_note_t;

    logic       clk  = 1'h0;
    logic       nrst = 1'h0;
    logic [3:0] or_in;
    logic       pulse_in, start_control, start_permit, arm_select, conv_req;
    logic [7:0] conv_index, converted_word;
    logic       or_out, pulse_out, start_out;
    int         cyc = 0;
    int         mismatches = 0;
    int         n_compared = 0;
    slfs_note_t notes[$];

    // ====================
    // Clock, edge count and instances
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    slfs_channel_model chan (.clk(clk), .or_in(or_in), .pulse_in(pulse_in),
        .start_control(start_control), .start_permit(start_permit),
        .arm_select(arm_select), .conv_req(conv_req), .conv_index(conv_index));

    slfs_top #(.PULSE_LEN(PL)) uut (.clk(clk), .nrst(nrst), .or_in(or_in), .or_out(or_out),
        .pulse_in(pulse_in), .pulse_out(pulse_out), .start_control(start_control),
        .start_permit(start_permit), .arm_select(arm_select), .start_out(start_out),
        .conv_req(conv_req), .conv_index(conv_index), .converted_word(converted_word));

    // ====================
    // Checking helpers
    function automatic logic [7:0] pick(input int s);
        case (s)
            0: return {7'h00, or_out};
            1: return {7'h00, pulse_out};
            2: return {7'h00, start_out};
            default: return converted_word;
        endcase
    endfunction : pick

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic note(input int at, input int sel, input logic [7:0] v);
        notes.push_back('{at, sel, v});
    endtask : note

    task automatic put(input int sel, input logic [7:0] v, output int p);
        chan.put(sel, v);
        p = cyc + 1;
    endtask : put

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    task automatic complete_run();
        if (notes.size() != 0) mismatches++;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // Watcher: compares every due note on the settled falling edge
    always @(negedge clk) begin
        for (int i = notes.size() - 1; i >= 0; i--) begin
            if (notes[i].at == cyc) begin
                check(pick(notes[i].sel), notes[i].val);
                notes.delete(i);
            end
        end
    end

    // Watchdog far beyond the expected few hundred cycles
    initial begin
        #(20 * 20000);
        mismatches++;
        complete_run();
    end

    // ====================
    // Main sequence
    initial begin
        int p;
        int q;
        logic [3:0] v;
        logic a;
        logic [7:0] idx;
        logic [7:0] last;
        p = 0;
        q = 0;
        v = 4'h0;
        a = 1'h0;
        idx = 8'h00;
        last = 8'h00;
        void'($urandom(20));
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        wait_cyc(4);
        note(cyc + 1, 3, 8'h00);
        for (int k = 0; k < 10; k++) begin
            v = (k == 0) ? 4'h0 : (k < 5) ? 4'h1 << (k - 1) : (k == 9) ? 4'hF : 4'($urandom);
            put(0, {4'h0, v}, p);
            note(p + 3, 0, {7'h00, |v});
            wait_cyc(3);
        end
        $display("test or done");
        // Pulse length and restart; output rises 3 edges after the pin falls
        put(1, 8'h01, p);
        note(p + 4, 1, 8'h00);
        wait_cyc(5);
        put(1, 8'h00, p);
        note(p + 2, 1, 8'h00);
        note(p + 3, 1, 8'h01);
        note(p + 2 + PL, 1, 8'h01);
        note(p + 3 + PL, 1, 8'h00);
        wait_cyc(PL + 6);
        put(1, 8'h01, p);
        put(1, 8'h00, p);
        wait_cyc(2);
        put(1, 8'h01, q);
        put(1, 8'h00, q);
        note(p + 3 + PL, 1, 8'h01);
        note(q + 2 + PL, 1, 8'h01);
        note(q + 3 + PL, 1, 8'h00);
        wait_cyc(PL + 6);
        $display("test pulse done");
        // Start latch in both arming settings
        for (int s = 0; s < 2; s++) begin
            a = s[0];
            put(3, 8'h00, p);
            put(4, {7'h00, a}, p);
            put(2, {7'h00, a}, p);
            wait_cyc(4);
            put(2, {7'h00, ~a}, p);
            note(p + 3, 2, 8'h00);
            wait_cyc(4);
            put(3, 8'h01, p);
            wait_cyc(3);
            put(2, {7'h00, a}, p);
            note(p + 3, 2, 8'h00);
            wait_cyc(4);
            put(2, {7'h00, ~a}, p);
            note(p + 2, 2, 8'h00);
            note(p + 3, 2, 8'h01);
            note(p + 8, 2, 8'h01);
            wait_cyc(8);
            put(3, 8'h00, p);
            note(p + 3, 2, 8'h00);
            wait_cyc(3);
            put(3, 8'h01, p);
            note(p + 5, 2, 8'h00);
            wait_cyc(5);
        end
        put(3, 8'h00, p);
        $display("test start done");
        // Table entries, out of range and random
        for (int k = 0; k < ENT + 3; k++) begin
            idx = (k < ENT) ? 8'(k) : (k == ENT) ? 8'(ENT) : (k == ENT + 1) ? 8'hFF
                : 8'($urandom % ENT);
            if (idx < ENT) last = slfs_pkg::TABLE_INIT[int'(idx) * 8 +: 8];
            put(6, idx, p);
            put(5, 8'h01, p);
            note(p + 3, 3, last);
            put(5, 8'h00, p);
            wait_cyc(4);
        end
        $display("test table done");
        wait_cyc(10);
        complete_run();
    end
endmodule : safety_logic_function_set_tb_top
